// *** logic/pcs_regs.svh ***
// register offsets, field positions and timing counts for the status block
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// register addresses on the management port
`define PCS_ADDR_CONFIG 5'h13
`define PCS_ADDR_CHIP_LINK_STATUS 5'h14

// configuration register fields
`define PCS_CFG_REPEATER_BIT 13
`define PCS_CFG_LINK_TEST_BIT 8
`define PCS_CFG_SYMBOL_MODE_BIT 4
`define PCS_CFG_SCRAMBLER_BYPASS_BIT 3
`define PCS_CFG_FIBER_BIT 2
// reserved bits 15 and 1 are held at zero
`define PCS_CFG_WRITE_MASK 16'h7ffd
`define PCS_CFG_RESET 16'h0000

// status register fields
`define PCS_STS_LINK_BIT 13
`define PCS_STS_DUPLEX_BIT 12
`define PCS_STS_SPEED_BIT 11
`define PCS_STS_AN_DONE_BIT 9
`define PCS_STS_PAGE_RCVD_BIT 8
`define PCS_STS_LOW_VOLT_BIT 2

// edges after reset release before straps are taken (sync settles)
`define PCS_STRAP_WAIT 2'h3

`endif

// *** logic/pcs_pkg.sv ***
// types shared by the chip status block
`default_nettype none

package pcs_pkg;

  // live and event status from the transceiver core, same clock
  typedef struct packed {
    logic link_up;
    logic full_duplex;
    logic speed_100;
    logic an_complete;
    logic page_rcvd;
  } pcs_core_status_t;

  // strap pins as sampled, plus auto-negotiation enable strap and low voltage fault pin
  typedef struct packed {
    logic an_enable;
    logic repeater_sel;
    logic link_test_sel;
    logic symbol_mode_sel;
    logic scrambler_bypass_sel;
    logic fiber_sel;
    logic low_voltage;
  } pcs_pins_t;

  // management port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pcs_mgmt_req_t;

endpackage

`default_nettype wire

// *** logic/pcs_sync2.sv ***
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none

module pcs_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

`default_nettype wire

// *** logic/pcs_chip_status.sv ***
// chip status register and strap-loaded configuration defaults
// Function
// - repeater select bit loads from first multifunction strap at reset
// - link test disable loads from config strap, zero if autoneg on
// - symbol mode bit loads from second multifunction strap at reset
// - scrambler bypass bit loads from third multifunction strap at reset
// - fiber select loads from fourth strap, zero if autoneg on
// - status link bit shows live link state, no latching
// - duplex bit shows present mode, 1 full, 0 half
// - speed bit reads 1 at 100 Mb/s, 0 at 10 Mb/s
// - autoneg complete bit latches high, mirrors standard completion bit
// - page received bit latches high when the core flags a received page
// - low voltage bit reads 1 once an undervoltage fault occurred
`timescale 1ns/1ns
`default_nettype none
`include "pcs_regs.svh"

module pcs_chip_status (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // pins and core status
  input wire pcs_pkg::pcs_pins_t pins_in,
  input wire pcs_pkg::pcs_core_status_t core_in,
  // management port
  input wire pcs_pkg::pcs_mgmt_req_t mgmt_in,
  output logic [15:0] rdata_out,
  output logic rd_valid_out,
  // configuration to the core
  output logic [15:0] config_out
);
  import pcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  pcs_pins_t pins_s;
  logic [1:0] strap_cnt;
  logic strap_loaded;
  logic an_done;
  logic page_rcvd;
  logic low_volt;

  pcs_sync2 #(
    .WIDTH($bits(pcs_pins_t))
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(pins_in),
    .sync_out(pins_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // decoding

  wire sel_cfg = (mgmt_in.addr == `PCS_ADDR_CONFIG);
  wire sel_sts = (mgmt_in.addr == `PCS_ADDR_CHIP_LINK_STATUS);
  wire load_now = !strap_loaded && (strap_cnt == `PCS_STRAP_WAIT);
  // writes before the strap load are dropped so defaults cannot be overtaken
  wire cfg_write = mgmt_in.wr && sel_cfg && strap_loaded;
  wire sts_read = mgmt_in.rd && sel_sts;

  function automatic logic [15:0] strap_defaults(input pcs_pins_t p);
    logic [15:0] v;
    v = `PCS_CFG_RESET;
    v[`PCS_CFG_REPEATER_BIT] = p.repeater_sel;
    v[`PCS_CFG_LINK_TEST_BIT] = p.link_test_sel && !p.an_enable;
    v[`PCS_CFG_SYMBOL_MODE_BIT] = p.symbol_mode_sel;
    v[`PCS_CFG_SCRAMBLER_BYPASS_BIT] = p.scrambler_bypass_sel;
    v[`PCS_CFG_FIBER_BIT] = p.fiber_sel && !p.an_enable;
    return v;
  endfunction

  wire [15:0] next_cfg_strap = strap_defaults(pins_s);

  // reserved status bits read as zero
  logic [15:0] sts_word;
  always_comb begin
    sts_word = 16'h0000;
    sts_word[`PCS_STS_LINK_BIT] = core_in.link_up;
    sts_word[`PCS_STS_DUPLEX_BIT] = core_in.full_duplex;
    sts_word[`PCS_STS_SPEED_BIT] = core_in.speed_100;
    sts_word[`PCS_STS_AN_DONE_BIT] = an_done;
    sts_word[`PCS_STS_PAGE_RCVD_BIT] = page_rcvd;
    sts_word[`PCS_STS_LOW_VOLT_BIT] = low_volt;
  end

  wire [15:0] next_rdata = sel_sts ? sts_word :
                           sel_cfg ? config_out : 16'h0000;

  // set wins over clear-on-read for each latched bit
  wire next_an_done = core_in.an_complete || (an_done && !sts_read);
  wire next_page_rcvd = core_in.page_rcvd || (page_rcvd && !sts_read);
  wire next_low_volt = pins_s.low_voltage || (low_volt && !sts_read);

  ////////////////////////////////////////////////////////////////////////
  // strap capture and configuration register

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_cnt <= 2'h0;
      strap_loaded <= 1'b0;
    end else if (!strap_loaded) begin
      strap_cnt <= strap_cnt + 2'h1;
      strap_loaded <= load_now;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      config_out <= `PCS_CFG_RESET;
    end else if (load_now) begin
      config_out <= next_cfg_strap;
    end else if (cfg_write) begin
      config_out <= mgmt_in.wdata & `PCS_CFG_WRITE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // latched status and read data

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      an_done <= 1'b0;
      page_rcvd <= 1'b0;
      low_volt <= 1'b0;
    end else begin
      an_done <= next_an_done;
      page_rcvd <= next_page_rcvd;
      low_volt <= next_low_volt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 16'h0000;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= mgmt_in.rd;
      if (mgmt_in.rd) begin
        rdata_out <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  AST_REPEATER_LOAD: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    load_now |=> config_out[`PCS_CFG_REPEATER_BIT] == $past(pins_s.repeater_sel))
    else $error("repeater bit not loaded from strap");

  AST_LINK_TEST_LOAD: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    load_now |=> config_out[`PCS_CFG_LINK_TEST_BIT] ==
      ($past(pins_s.link_test_sel) && !$past(pins_s.an_enable)))
    else $error("link test default wrong");

  AST_SYMBOL_LOAD: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    load_now |=> config_out[`PCS_CFG_SYMBOL_MODE_BIT] ==
      $past(pins_s.symbol_mode_sel))
    else $error("symbol mode default wrong");

  AST_SCRAMBLER_LOAD: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    load_now |=> config_out[`PCS_CFG_SCRAMBLER_BYPASS_BIT] ==
      $past(pins_s.scrambler_bypass_sel))
    else $error("scrambler bypass default wrong");

  AST_FIBER_LOAD: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    load_now |=> config_out[`PCS_CFG_FIBER_BIT] ==
      ($past(pins_s.fiber_sel) && !$past(pins_s.an_enable)))
    else $error("fiber default wrong");

  AST_LINK_LIVE: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    sts_read |=> rd_valid_out &&
      rdata_out[`PCS_STS_LINK_BIT] == $past(core_in.link_up))
    else $error("link bit not live");

  AST_DUPLEX_LIVE: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    sts_read |=> rdata_out[`PCS_STS_DUPLEX_BIT] == $past(core_in.full_duplex))
    else $error("duplex bit wrong");

  AST_SPEED_LIVE: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    sts_read |=> rdata_out[`PCS_STS_SPEED_BIT] == $past(core_in.speed_100))
    else $error("speed bit wrong");

  AST_AN_LATCH: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    core_in.an_complete ##1 sts_read |=> rdata_out[`PCS_STS_AN_DONE_BIT])
    else $error("autoneg complete not latched");

  AST_PAGE_LATCH: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    core_in.page_rcvd |=> page_rcvd)
    else $error("page received not latched");

  AST_LOW_VOLT: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    pins_s.low_voltage |=> low_volt)
    else $error("low voltage fault not flagged");

  AST_CLEAR_ON_READ: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    sts_read && !core_in.an_complete && !core_in.page_rcvd |=>
      !an_done && !page_rcvd)
    else $error("latched bits not cleared by read");

  AST_STATUS_WRITE_IGNORED: assert property (@(posedge sys_clk_in)
    disable iff (!reset_n_in)
    mgmt_in.wr && sel_sts && strap_loaded |=> $stable(config_out))
    else $error("status write changed state");

  COV_STRAP_LOAD: cover property (@(posedge sys_clk_in)
    disable iff (!reset_n_in) load_now);
  COV_AN_READ: cover property (@(posedge sys_clk_in)
    disable iff (!reset_n_in) sts_read && an_done);
  COV_CFG_WRITE: cover property (@(posedge sys_clk_in)
    disable iff (!reset_n_in) cfg_write ##2 mgmt_in.rd && sel_cfg);

endmodule

`default_nettype wire

// *** sim/pcs_mac_model.sv ***
// management master model driving the parallel strobe port
`timescale 1ns/1ns
`default_nettype none

module pcs_mac_model (
  // clock
  input wire logic sys_clk_in,
  // management port
  output var pcs_pkg::pcs_mgmt_req_t mgmt_out,
  input wire logic [15:0] rdata_in,
  input wire logic rd_valid_in
);
  import pcs_pkg::*;

  initial begin
    mgmt_out = '{rd: 1'b0, wr: 1'b0, addr: 5'h0a, wdata: 16'h5a5a};
  end

  ////////////////////////////////////////////////////////////////////////////
  // idle bus shows the inverse of the last value, never a stale copy
  task automatic release_bus();
    mgmt_out.rd = 1'b0;
    mgmt_out.wr = 1'b0;
    mgmt_out.addr = ~mgmt_out.addr;
    mgmt_out.wdata = ~mgmt_out.wdata;
  endtask

  task automatic wr(input logic [4:0] addr, input logic [15:0] data);
    @(negedge sys_clk_in);
    mgmt_out.wr = 1'b1;
    mgmt_out.addr = addr;
    mgmt_out.wdata = data;
    @(negedge sys_clk_in);
    release_bus();
  endtask

  // answer is read half a cycle after the taking edge
  task automatic rd(input logic [4:0] addr, output logic [15:0] data,
                    output logic ok);
    @(negedge sys_clk_in);
    mgmt_out.rd = 1'b1;
    mgmt_out.addr = addr;
    @(negedge sys_clk_in);
    ok = rd_valid_in;
    data = rdata_in;
    release_bus();
  endtask
endmodule

`default_nettype wire

// *** sim/tb_phy_chip_status_and_strap_defaults.sv ***
// testbench for the chip status block and strap defaults
`timescale 1ns/1ns
`default_nettype none
`include "pcs_regs.svh"

module tb_phy_chip_status_and_strap_defaults;
  import pcs_pkg::*;

  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  pcs_pins_t pins = '0;
  pcs_core_status_t core = '0;
  pcs_mgmt_req_t mgmt;
  logic [15:0] rdata;
  logic [15:0] cfg;
  logic rd_valid;
  int n_errors = 0;
  int n_checks = 0;

  pcs_chip_status i_dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .pins_in(pins), .core_in(core), .mgmt_in(mgmt), .rdata_out(rdata),
    .rd_valid_out(rd_valid), .config_out(cfg));

  pcs_mac_model i_mac (.sys_clk_in(sys_clk_in), .mgmt_out(mgmt),
    .rdata_in(rdata), .rd_valid_in(rd_valid));

  initial begin
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input string what, input logic [4:0] a,
                        input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    i_mac.rd(a, d, ok);
    chk({what, " valid"}, 16'h0001, {15'h0000, ok});
    chk(what, exp, d);
    // valid is a one-cycle pulse while read data holds
    @(negedge sys_clk_in);
    chk({what, " valid drop"}, 16'h0000, {15'h0000, rd_valid});
    chk({what, " held"}, exp, rdata);
  endtask

  task automatic strap_case(input pcs_pins_t p, input logic [15:0] exp);
    @(negedge sys_clk_in);
    reset_n_in = 1'b0;
    pins = p;
    repeat (4) @(negedge sys_clk_in);
    reset_n_in = 1'b1;
    // write lands before the strap load and must be refused
    i_mac.wr(`PCS_ADDR_CONFIG, 16'hffff);
    chk("early write", 16'h0000, cfg);
    repeat (4) @(negedge sys_clk_in);
    chk("config_out", exp, cfg);
    rd_chk("config read", `PCS_ADDR_CONFIG, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_straps();
    strap_case(7'b0111110, 16'h211c);
    strap_case(7'b1111110, 16'h2018);
    strap_case(7'b0101010, 16'h2014);
    strap_case(7'b0010100, 16'h0108);
    $display("test straps done");
  endtask

  task automatic t_live();
    for (int i = 0; i < 8; i++) begin
      core = '{link_up: i[2], full_duplex: i[1], speed_100: i[0],
               an_complete: 1'b0, page_rcvd: 1'b0};
      rd_chk("live status", `PCS_ADDR_CHIP_LINK_STATUS,
             {2'b00, i[2:0], 11'h000});
    end
    core = '0;
    $display("test live done");
  endtask

  task automatic t_latch();
    @(negedge sys_clk_in);
    core.an_complete = 1'b1;
    @(negedge sys_clk_in);
    core.an_complete = 1'b0;
    rd_chk("an done", 5'h14, 16'h0200);
    rd_chk("an cleared", 5'h14, 16'h0000);
    core.page_rcvd = 1'b1;
    rd_chk("page held", 5'h14, 16'h0100);
    rd_chk("page still", 5'h14, 16'h0100);
    core.page_rcvd = 1'b0;
    rd_chk("page latched", 5'h14, 16'h0100);
    rd_chk("page cleared", 5'h14, 16'h0000);
    // fault pulse passes the pin synchroniser first
    pins.low_voltage = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    pins.low_voltage = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    rd_chk("low voltage", 5'h14, 16'h0004);
    rd_chk("low voltage cleared", 5'h14, 16'h0000);
    $display("test latch done");
  endtask

  task automatic t_write();
    i_mac.wr(5'h14, 16'hffff);
    rd_chk("status after write", 5'h14, 16'h0000);
    i_mac.wr(`PCS_ADDR_CONFIG, 16'hffff);
    chk("config reserved", 16'h7ffd, cfg);
    rd_chk("config readback", `PCS_ADDR_CONFIG, 16'h7ffd);
    i_mac.wr(`PCS_ADDR_CONFIG, 16'h0000);
    chk("config cleared", 16'h0000, cfg);
    rd_chk("unmapped read", 5'h1f, 16'h0000);
    $display("test write done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // whole run is about 130 cycles
  initial begin
    #(3000 * 50);
    n_errors++;
    print_verdict();
  end

  initial begin
    t_straps();
    t_live();
    t_latch();
    t_write();
    print_verdict();
  end
endmodule

`default_nettype wire
